/* hw/sfi_spi_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Serial peripheral port with status flags, masks and one request
// Assumes: Pins synchronous to clock; APB slave with zero wait states
// Notes:   Output enables are active low
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Receive-full and fault share one enable mask
// - Transmit-empty gated by transmit enable mask
// - Match flag gated by match enable mask
// - Any enabled flag raises the single request
// - Fault sets flag, aborts transfer, clears master
// - Fault request stays while fault flag set
// - Receive-full set after complete byte or word
// - Held receive-full discards the next word
// - Transmit-empty set once word enters shifter, as master once transfer starts
// - Match compares low byte or whole word
// - Primary control bit layout
// - Secondary control bit layout
// - Baud prescale and divisor fields
// - Status bit layout, low nibble zero
// - High match writes ignored in byte mode
// - High data byte used in word mode
// - Bit order, clock phase and polarity
// - Single-wire pins and run in wait
// - Status read then control write clears fault
// - No request unless module enabled
// - Fault forces slave with pins released
//////////////////////////////////////////////////////////////////////////////
//
// Register access over APB and the address map are this design's own decisions.
module sfi_spi_top
    import sfi_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        wait_mode,
    input  wire logic        serial_clock_pin_in,
    output sfi_pin_s         serial_clock_pin,
    input  wire logic        mosi_in,
    output sfi_pin_s         mosi_pin,
    input  wire logic        miso_in,
    output sfi_pin_s         miso_pin,
    input  wire logic        ss_n_in,
    output sfi_pin_s         ss_n_pin
);

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  ctl1_r;
    logic [7:0]  ctl2_r;
    logic [7:0]  baud_r;
    logic [7:0]  match_h_r;
    logic [7:0]  match_l_r;
    logic [15:0] tx_data_r;
    logic [15:0] rx_data_r;
    logic        rx_full_flag_r;
    logic        tx_empty_flag_r;
    logic        match_flag_r;
    logic        fault_flag_r;
    logic        arm_rx_r;
    logic        arm_tx_r;
    logic        arm_fault_r;
    logic [31:0] prdata_r;
    sfi_state_e  state_r;
    logic [15:0] shift_r;
    logic [4:0]  edge_cnt_r;
    logic [10:0] div_cnt_r;
    logic        sck_r;
    logic        sck_prev_r;
    logic        in_bit_r;

    //////////////////////////////////////////////////////////////////////////
    // Control fields
    wire rx_fault_irq_en  = ctl1_r[B_RX_FAULT_IRQ_EN];
    wire module_enable    = ctl1_r[B_MODULE_ENABLE];
    wire tx_empty_irq_en  = ctl1_r[B_TX_EMPTY_IRQ_EN];
    wire master_select    = ctl1_r[B_MASTER_SELECT];
    wire clock_polarity   = ctl1_r[B_CLOCK_POLARITY];
    wire clock_phase      = ctl1_r[B_CLOCK_PHASE];
    wire select_output_en = ctl1_r[B_SELECT_OUT_EN];
    wire lsb_first        = ctl1_r[B_LSB_FIRST];
    wire match_irq_en     = ctl2_r[B_MATCH_IRQ_EN];
    wire word_width_sel   = ctl2_r[B_WORD_WIDTH_SEL];
    wire fault_detect_en  = ctl2_r[B_FAULT_DETECT_EN];
    wire bidir_output_en  = ctl2_r[B_BIDIR_OUTPUT_EN];
    wire halt_in_wait     = ctl2_r[B_HALT_IN_WAIT];
    wire single_wire_mode = ctl2_r[B_SINGLE_WIRE];
    wire [2:0] prescale   = baud_r[B_PRESCALE_LO +: 3];
    wire [2:0] divisor    = baud_r[B_DIVISOR_LO +: 3];

    //////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_acc    = access_ph & pwrite;
    wire rd_acc    = access_ph & ~pwrite;
    wire hit_ctl1    = (paddr == OFS_CTL1);
    wire hit_ctl2    = (paddr == OFS_CTL2);
    wire hit_baud    = (paddr == OFS_BAUD);
    wire hit_status  = (paddr == OFS_STATUS);
    wire hit_match_h = (paddr == OFS_MATCH_H);
    wire hit_match_l = (paddr == OFS_MATCH_L);
    wire hit_data_h  = (paddr == OFS_DATA_H);
    wire hit_data_l  = (paddr == OFS_DATA_L);
    wire mapped = hit_ctl1 | hit_ctl2 | hit_baud | hit_status |
                  hit_match_h | hit_match_l | hit_data_h | hit_data_l;
    wire [7:0] status_val = {rx_full_flag_r, match_flag_r, tx_empty_flag_r,
                             fault_flag_r, 4'h0};
    wire [7:0] rd_mux = hit_ctl1    ? ctl1_r :
                        hit_ctl2    ? ctl2_r :
                        hit_baud    ? baud_r :
                        hit_status  ? status_val :
                        hit_match_h ? match_h_r :
                        hit_match_l ? match_l_r :
                        hit_data_h  ? rx_data_r[15:8] :
                        hit_data_l  ? rx_data_r[7:0] : 8'h00;
    wire wr_ctl1    = wr_acc & hit_ctl1;
    wire wr_ctl2    = wr_acc & hit_ctl2;
    wire wr_baud    = wr_acc & hit_baud;
    wire wr_match_h = wr_acc & hit_match_h & word_width_sel;
    wire wr_match_l = wr_acc & hit_match_l;
    wire wr_data_h  = wr_acc & hit_data_h;
    wire wr_data_l  = wr_acc & hit_data_l;
    wire rd_status  = rd_acc & hit_status;
    wire rd_data_l  = rd_acc & hit_data_l;

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = prdata_r;

    //////////////////////////////////////////////////////////////////////////
    // Transfer engine decode
    wire [4:0]  last_edge = word_width_sel ? LAST_EDGE_WORD : LAST_EDGE_BYTE;
    wire [10:0] half_cnt  = 11'({7'h00, 4'({1'b0, prescale}) + 4'h1} << divisor);
    wire        is_run    = (state_r == ST_RUN);
    wire        stall     = halt_in_wait & wait_mode & master_select;
    wire        fault_evt = module_enable & master_select & fault_detect_en &
                            ~select_output_en & ~ss_n_in;
    wire        m_tick    = is_run & master_select & ~stall & (div_cnt_r == 11'h000);
    wire        s_edge    = is_run & ~master_select & (serial_clock_pin_in != sck_prev_r);
    wire        any_edge  = m_tick | s_edge;
    wire        smp_edge  = any_edge & (edge_cnt_r[0] == clock_phase);
    wire        sft_edge  = any_edge & (edge_cnt_r[0] != clock_phase) &
                            ~(clock_phase & (edge_cnt_r == 5'h00));
    wire        last_hit  = any_edge & (edge_cnt_r == last_edge);
    wire        data_in   = (master_select ^ single_wire_mode) ? miso_in : mosi_in;
    wire        fin_bit   = clock_phase ? data_in : in_bit_r;
    wire        dout      = lsb_first ? shift_r[0] :
                            (word_width_sel ? shift_r[15] : shift_r[7]);
    wire        s_start   = ~is_run & module_enable & ~master_select & ~ss_n_in &
                            ~fault_flag_r;
    wire        s_abort   = is_run & ~master_select & ss_n_in;
    wire        load_tx   = ~is_run & module_enable & ~tx_empty_flag_r &
                            (master_select | ss_n_in);
    wire        m_start   = load_tx & master_select & ~stall;
    wire        word_done = last_hit & module_enable;

    function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b,
                                             input logic lsb, input logic wide);
        logic [15:0] r;
        r = {sh[14:0], b};
        if (lsb) begin
            r = wide ? {b, sh[15:1]} : {8'h00, b, sh[7:1]};
        end
        return r;
    endfunction : shift_in

    wire [15:0] sft_val  = shift_in(shift_r, in_bit_r, lsb_first, word_width_sel);
    wire [15:0] fin_val  = shift_in(shift_r, fin_bit, lsb_first, word_width_sel);
    wire [15:0] rx_word  = word_width_sel ? fin_val : {8'h00, fin_val[7:0]};
    wire        match_eq = word_width_sel ?
                           (rx_word == {match_h_r, match_l_r}) :
                           (rx_word[7:0] == match_l_r);
    wire        rx_take  = word_done & ~rx_full_flag_r;

    //////////////////////////////////////////////////////////////////////////
    // Flag next values: hardware set wins over software clear
    wire clr_rx    = rd_data_l & arm_rx_r;
    wire clr_tx    = wr_data_l & arm_tx_r;
    wire clr_fault = wr_ctl1 & arm_fault_r;
    wire rx_full_nxt  = rx_take | (rx_full_flag_r & ~clr_rx);
    wire match_nxt    = (rx_take & match_eq) | (match_flag_r & ~clr_rx);
    wire tx_empty_nxt = (load_tx & (master_select ? m_start : 1'b1)) |
                        (tx_empty_flag_r & ~clr_tx);
    wire fault_nxt    = fault_evt | (fault_flag_r & ~clr_fault);

    wire [7:0] ctl1_wr = wr_ctl1 ? pwdata[7:0] : ctl1_r;
    wire [7:0] ctl1_nxt = fault_evt ? (ctl1_wr & ~(8'h01 << B_MASTER_SELECT)) :
                          ctl1_wr;
    wire [7:0] ctl2_wr = wr_ctl2 ? (pwdata[7:0] & CTL2_IMPL_MASK) : ctl2_r;
    wire [7:0] ctl2_nxt = (fault_evt & single_wire_mode) ?
                          (ctl2_wr & ~(8'h01 << B_BIDIR_OUTPUT_EN)) : ctl2_wr;

    //////////////////////////////////////////////////////////////////////////
    // Request toward the processor
    assign irq = module_enable &
                 ((rx_fault_irq_en & (rx_full_flag_r | fault_flag_r)) |
                  (tx_empty_irq_en & tx_empty_flag_r) |
                  (match_irq_en & match_flag_r));

    //////////////////////////////////////////////////////////////////////////
    // Pins
    wire drive_m  = module_enable & master_select & ~fault_flag_r;
    wire drive_s  = module_enable & ~master_select & ~fault_flag_r & ~ss_n_in;
    wire data_oe  = ~single_wire_mode | bidir_output_en;
    wire ss_drive = drive_m & select_output_en & fault_detect_en;

    assign serial_clock_pin.o    = sck_r;
    assign serial_clock_pin.oe_n = ~drive_m;
    assign mosi_pin.o            = dout;
    assign mosi_pin.oe_n         = ~(drive_m & data_oe);
    assign miso_pin.o            = dout;
    assign miso_pin.oe_n         = ~(drive_s & data_oe);
    assign ss_n_pin.o            = ~is_run;
    assign ss_n_pin.oe_n         = ~ss_drive;

    //////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl1_r    <= RST_CTL1;
            ctl2_r    <= RST_CTL2;
            baud_r    <= RST_BAUD;
            match_h_r <= 8'h00;
            match_l_r <= 8'h00;
            tx_data_r <= 16'h0000;
            prdata_r  <= 32'h0000_0000;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            if (wr_baud) begin
                baud_r <= pwdata[7:0] & BAUD_IMPL_MASK;
            end
            if (wr_match_h) begin
                match_h_r <= pwdata[7:0];
            end
            if (wr_match_l) begin
                match_l_r <= pwdata[7:0];
            end
            if (wr_data_h) begin
                tx_data_r[15:8] <= pwdata[7:0];
            end
            if (wr_data_l) begin
                tx_data_r[7:0] <= pwdata[7:0];
            end
            if (setup_ph) begin
                prdata_r <= {24'h000000, rd_mux};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Flags and status-read arming
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_full_flag_r  <= 1'b0;
            tx_empty_flag_r <= 1'b1;
            match_flag_r    <= 1'b0;
            fault_flag_r    <= 1'b0;
            arm_rx_r        <= 1'b0;
            arm_tx_r        <= 1'b0;
            arm_fault_r     <= 1'b0;
        end else begin
            rx_full_flag_r  <= rx_full_nxt;
            tx_empty_flag_r <= tx_empty_nxt;
            match_flag_r    <= match_nxt;
            fault_flag_r    <= fault_nxt;
            if (rd_status) begin
                arm_rx_r    <= prdata_r[B_RX_FULL_FLAG];
                arm_tx_r    <= prdata_r[B_TX_EMPTY_FLAG];
                arm_fault_r <= prdata_r[B_FAULT_FLAG];
            end else begin
                arm_rx_r    <= arm_rx_r & ~clr_rx;
                arm_tx_r    <= arm_tx_r & ~clr_tx;
                arm_fault_r <= arm_fault_r & ~clr_fault;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Shifter and serial clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            shift_r    <= 16'h0000;
            edge_cnt_r <= 5'h00;
            div_cnt_r  <= 11'h000;
            sck_r      <= 1'b0;
            sck_prev_r <= 1'b0;
            in_bit_r   <= 1'b0;
            rx_data_r  <= 16'h0000;
        end else begin
            sck_prev_r <= serial_clock_pin_in;
            if (rx_take) begin
                rx_data_r <= rx_word;
            end
            case (state_r)
                ST_IDLE: begin
                    sck_r      <= clock_polarity;
                    edge_cnt_r <= 5'h00;
                    div_cnt_r  <= half_cnt - 11'h001;
                    if (load_tx) begin
                        shift_r <= tx_data_r;
                    end
                    if (m_start | s_start) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (m_tick) begin
                        div_cnt_r <= half_cnt - 11'h001;
                        sck_r     <= ~sck_r;
                    end else if (~stall) begin
                        div_cnt_r <= div_cnt_r - 11'h001;
                    end
                    if (smp_edge) begin
                        in_bit_r <= data_in;
                    end
                    if (sft_edge) begin
                        shift_r <= sft_val;
                    end
                    if (any_edge) begin
                        edge_cnt_r <= edge_cnt_r + 5'h01;
                    end
                    if (last_hit) begin
                        shift_r <= fin_val;
                    end
                    if (last_hit | fault_evt | s_abort | ~module_enable) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : sfi_spi_top

/* pkg/sfi_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and types for the serial port flag and interrupt block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Offsets are byte addresses
//////////////////////////////////////////////////////////////////////////////
package sfi_pkg;

    localparam logic [7:0] OFS_CTL1    = 8'h00;
    localparam logic [7:0] OFS_CTL2    = 8'h04;
    localparam logic [7:0] OFS_BAUD    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_MATCH_H = 8'h10;
    localparam logic [7:0] OFS_MATCH_L = 8'h14;
    localparam logic [7:0] OFS_DATA_H  = 8'h18;
    localparam logic [7:0] OFS_DATA_L  = 8'h1c;

    // Primary control bits
    localparam int B_RX_FAULT_IRQ_EN = 7;
    localparam int B_MODULE_ENABLE   = 6;
    localparam int B_TX_EMPTY_IRQ_EN = 5;
    localparam int B_MASTER_SELECT   = 4;
    localparam int B_CLOCK_POLARITY  = 3;
    localparam int B_CLOCK_PHASE     = 2;
    localparam int B_SELECT_OUT_EN   = 1;
    localparam int B_LSB_FIRST       = 0;

    // Secondary control bits
    localparam int B_MATCH_IRQ_EN    = 7;
    localparam int B_WORD_WIDTH_SEL  = 6;
    localparam int B_FAULT_DETECT_EN = 4;
    localparam int B_BIDIR_OUTPUT_EN = 3;
    localparam int B_HALT_IN_WAIT    = 1;
    localparam int B_SINGLE_WIRE     = 0;
    localparam logic [7:0] CTL2_IMPL_MASK = 8'hdb;

    // Baud fields
    localparam int B_PRESCALE_LO = 4;
    localparam int B_DIVISOR_LO  = 0;
    localparam logic [7:0] BAUD_IMPL_MASK = 8'h77;

    // Status bits
    localparam int B_RX_FULL_FLAG  = 7;
    localparam int B_MATCH_FLAG    = 6;
    localparam int B_TX_EMPTY_FLAG = 5;
    localparam int B_FAULT_FLAG    = 4;

    localparam logic [7:0] RST_CTL1 = 8'h04;
    localparam logic [7:0] RST_CTL2 = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;

    // Index of the last clock edge of a word
    localparam logic [4:0] LAST_EDGE_BYTE = 5'h0f;
    localparam logic [4:0] LAST_EDGE_WORD = 5'h1f;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } sfi_state_e;

    typedef struct packed {
        logic o;
        logic oe_n;
    } sfi_pin_s;

endpackage : sfi_pkg

/* verification/sfi_spi_chk.sv */
////////////////////////////////////////////////////////////
// Purpose: Port assertions for the serial flag block
// Assumes: Control bits tracked from APB writes
// Notes:   Bind follows the module
////////////////////////////////////////////////////////////
module sfi_spi_chk
    import sfi_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        ss_n_in,
    input wire sfi_pin_s    serial_clock_pin,
    input wire sfi_pin_s    mosi_pin
);
    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic [5:0] edges_r;
    logic       sck_q_r;
    wire        acc    = psel && penable;
    wire        wr_c1  = acc && pwrite && paddr == OFS_CTL1;
    wire        wr_c2  = acc && pwrite && paddr == OFS_CTL2;
    wire        wr_dl  = acc && pwrite && paddr == OFS_DATA_L;
    wire        mapped = paddr[1:0] == 2'h0 && paddr <= OFS_DATA_L;
    wire        toggle = !serial_clock_pin.oe_n && serial_clock_pin.o != sck_q_r;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Shadow of control bits and count of clock edges per word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c1_r    <= RST_CTL1;
            c2_r    <= RST_CTL2;
            edges_r <= 6'h00;
            sck_q_r <= 1'b0;
        end else begin
            c1_r    <= wr_c1 ? pwdata[7:0] : c1_r;
            c2_r    <= wr_c2 ? (pwdata[7:0] & CTL2_IMPL_MASK) : c2_r;
            edges_r <= (wr_dl || wr_c2) ? 6'h00 : edges_r + {5'h00, toggle && edges_r != 6'h3f};
            sck_q_r <= serial_clock_pin.o;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence read_s(logic [7:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    sequence fault_s;
        c1_r[6] && c1_r[4] && c2_r[4] && !c1_r[1] && !ss_n_in;
    endsequence
    bus_ready_a: assert property (acc |-> pready) else $error("no ready");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("bad error");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("high read bits set");
    status_nibble_a: assert property (read_s(OFS_STATUS) |-> prdata[3:0] == 4'h0)
        else $error("status nibble set");
    disabled_quiet_a: assert property (!c1_r[6] |-> !irq) else $error("irq disabled");
    masked_quiet_a: assert property (!c1_r[7] && !c1_r[5] && !c2_r[7] |-> !irq)
        else $error("irq masked");
    fault_release_a: assert property (fault_s |-> ##[1:3] (serial_clock_pin.oe_n && mosi_pin.oe_n))
        else $error("pins driven in fault");
    fault_irq_a: assert property (fault_s ##0 c1_r[7] |-> ##[1:3] irq)
        else $error("no fault irq");
    edge_count_a: assert property (edges_r <= (c2_r[6] ? 6'd32 : 6'd16))
        else $error("too many clock edges");
endmodule : sfi_spi_chk

bind sfi_spi_top sfi_spi_chk sfi_spi_chk_inst (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .ss_n_in, .serial_clock_pin, .mosi_pin
);

/* verification/sfi_slave_model.sv */
////////////////////////////////////////////////////////////
// Purpose: Far-side serial slave, mode 0, most significant bit first
// Assumes: Selected by the block's select output
// Notes:   Deselected data line shows the inverse of its last bit
////////////////////////////////////////////////////////////
module sfi_slave_model
    import sfi_pkg::*;
(
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic [15:0] tx_word,
    output logic             miso,
    output logic [15:0]      rx_word
);
    logic [15:0] sh_r = 16'h0000;
    initial rx_word = 16'h0000;
    always @(negedge sel_n) begin
        sh_r = tx_word;
        rx_word = 16'h0000;
    end
    always @(posedge sck) if (!sel_n) rx_word <= {rx_word[14:0], mosi};
    always @(negedge sck) if (!sel_n) sh_r <= {sh_r[14:0], 1'b0};
    assign miso = sel_n ? ~sh_r[15] : sh_r[15];
endmodule : sfi_slave_model

/* verification/tb.sv */
////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the serial flag block
// Assumes: APB master tasks, slave model on the far side
// Notes:   Reset values and register table first, then request masks, transfers, faults and reset
////////////////////////////////////////////////////////////
module tb
    import sfi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] x; logic err;} sfi_row_s;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        ss_n_in = 1'b1;
    logic        wait_mode = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, e, miso_w;
    logic [15:0] slv_tx = 16'h0000;
    logic [15:0] slv_rx;
    sfi_pin_s    sck_p, mosi_p, miso_p, ss_p;
    int          num_errors = 0;
    int          comparisons = 0;
    sfi_row_s    rows [9] = '{'{OFS_CTL2, 8'hff, 8'hdb, 1'b0}, '{OFS_CTL2, 8'h24, 8'h00, 1'b0},
        '{OFS_BAUD, 8'hff, 8'h77, 1'b0}, '{OFS_BAUD, 8'h88, 8'h00, 1'b0},
        '{OFS_MATCH_H, 8'h3c, 8'h00, 1'b0}, '{OFS_MATCH_L, 8'ha5, 8'ha5, 1'b0},
        '{OFS_STATUS, 8'hff, 8'h20, 1'b0}, '{8'h20, 8'hff, 8'h00, 1'b1},
        '{OFS_DATA_H, 8'h5a, 8'h00, 1'b0}};
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (x)); end end
    always #25 clock = ~clock;
    sfi_spi_top sfi_spi_top_inst (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irq, .wait_mode, .serial_clock_pin_in(sck_p.o ^ sck_p.oe_n),
        .serial_clock_pin(sck_p), .mosi_in(mosi_p.o ^ mosi_p.oe_n), .mosi_pin(mosi_p),
        .miso_in(miso_p.oe_n ? miso_w : miso_p.o), .miso_pin(miso_p), .ss_n_in, .ss_n_pin(ss_p)
    );
    sfi_slave_model sfi_slave_model_inst (
        .sck(sck_p.o ^ sck_p.oe_n), .sel_n(ss_p.o | ss_p.oe_n), .mosi(mosi_p.o ^ mosi_p.oe_n),
        .tx_word(slv_tx), .miso(miso_w), .rx_word(slv_rx)
    );
    ////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, {24'h0, x})
    endtask : rdchk
    task automatic xfer(input logic [7:0] hi, input logic [7:0] lo);
        apb(1'b1, OFS_DATA_H, {24'h0, hi});
        apb(1'b0, OFS_STATUS, 32'h0);
        apb(1'b1, OFS_DATA_L, {24'h0, lo});
        while (ss_p.o !== 1'b0) @(posedge clock);
        while (ss_p.o !== 1'b1) @(posedge clock);
        repeat (2) @(posedge clock);
    endtask : xfer
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(OFS_CTL1, RST_CTL1);
        rdchk(OFS_STATUS, 8'h20);
        foreach (rows[k]) begin
            apb(1'b1, rows[k].a, {24'h0, rows[k].d});
            apb(1'b0, rows[k].a, 32'h0);
            `CHK({e, rd[7:0]}, {rows[k].err, rows[k].x})
        end
        apb(1'b1, OFS_CTL1, 32'h20);
        `CHK(irq, 1'b0)
        apb(1'b1, OFS_CTL1, 32'h60);
        `CHK(irq, 1'b1)
        apb(1'b1, OFS_CTL1, 32'h40);
        `CHK(irq, 1'b0)
        apb(1'b1, OFS_CTL2, 32'h90);
        apb(1'b1, OFS_BAUD, 32'h11);
        apb(1'b1, OFS_CTL1, 32'h52);
        slv_tx = 16'ha500;
        wait_mode <= 1'b1;
        xfer(8'h00, 8'h3c);
        `CHK(slv_rx[7:0], 8'h3c)
        `CHK(irq, 1'b1)
        rdchk(OFS_STATUS, 8'he0);
        rdchk(OFS_DATA_L, 8'ha5);
        rdchk(OFS_STATUS, 8'h20);
        apb(1'b1, OFS_CTL2, 32'h10);
        apb(1'b1, OFS_CTL1, 32'hd2);
        slv_tx = 16'h7700;
        xfer(8'h00, 8'h01);
        `CHK(irq, 1'b1)
        slv_tx = 16'h1100;
        xfer(8'h00, 8'h02);
        rdchk(OFS_STATUS, 8'ha0);
        rdchk(OFS_DATA_L, 8'h77);
        apb(1'b1, OFS_CTL2, 32'h50);
        apb(1'b1, OFS_MATCH_H, 32'h12);
        apb(1'b1, OFS_MATCH_L, 32'h34);
        rdchk(OFS_MATCH_H, 8'h12);
        slv_tx = 16'h1234;
        xfer(8'h9c, 8'h3f);
        `CHK(slv_rx, 16'h9c3f)
        rdchk(OFS_STATUS, 8'he0);
        rdchk(OFS_DATA_H, 8'h12);
        rdchk(OFS_DATA_L, 8'h34);
        apb(1'b1, OFS_CTL2, 32'h10);
        apb(1'b1, OFS_CTL1, 32'h53);
        slv_tx = 16'h8000;
        xfer(8'h00, 8'h01);
        `CHK(slv_rx[7:0], 8'h80)
        rdchk(OFS_STATUS, 8'ha0);
        rdchk(OFS_DATA_L, 8'h01);
        apb(1'b1, OFS_CTL1, 32'hd0);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK(irq, 1'b1)
        `CHK({sck_p.oe_n, mosi_p.oe_n, miso_p.oe_n}, 3'h7)
        rdchk(OFS_CTL1, 8'hc0);
        rdchk(OFS_STATUS, 8'h30);
        ss_n_in <= 1'b1;
        apb(1'b1, OFS_CTL1, 32'hd0);
        rdchk(OFS_STATUS, 8'h20);
        `CHK(irq, 1'b0)
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(OFS_CTL1, RST_CTL1);
        `CHK(irq, 1'b0)
        wrap_up();
    end
endmodule : tb
